// *** gvtd_pkg.sv ***
package gvtd_pkg;

  // register byte addresses
  localparam logic [11:0] GVTD_ADDR_CTRL   = 12'h000;
  localparam logic [11:0] GVTD_ADDR_STATUS = 12'h004;
  localparam logic [11:0] GVTD_ADDR_COUNT  = 12'h008;
  localparam logic [11:0] GVTD_ADDR_SUCW   = 12'h320;

  // control register fields
  localparam int GVTD_CTRL_CONT_BIT    = 0;
  localparam int GVTD_CTRL_RESTART_BIT = 1;

  // status register fields
  localparam int GVTD_STAT_ACTIVE_BIT = 8;
  localparam int GVTD_STAT_SEQ_LSB    = 16;

  // values after reset or restart, and the crc polynomial
  localparam logic [3:0]  GVTD_CODE_RESET = 4'h4;
  localparam logic [15:0] GVTD_CRC_INIT   = 16'hffff;
  localparam logic [15:0] GVTD_CRC_POLY   = 16'h1021;

  // packet framing, one byte per index
  localparam int          GVTD_PKT_BYTES = 14;
  localparam logic [3:0]  GVTD_IDX_LAST  = 4'hd;
  localparam logic [3:0]  GVTD_IDX_SEQ_HI = 4'h2;
  localparam logic [3:0]  GVTD_IDX_SEQ_LO = 4'h3;
  localparam logic [3:0]  GVTD_IDX_DATA  = 4'hb;

  // expected byte values, index 0 in the low byte
  localparam logic [13:0][7:0] GVTD_EXPECT = {
    8'h00, 8'h00,          // checksum, covered by the crc residue
    8'h00, 8'h00,          // application data, upper bits zero
    8'h00, 8'h01,          // pad, subtype
    8'hc0, 8'h11,          // service type, service version/checksum flag/ack
    8'h07, 8'h00,          // length
    8'h00, 8'hc0,          // sequence flags and sequence count bits
    8'h7c, 8'h1c           // version/type/header flag/process id/category
  };

  // bits that must match the expected value
  localparam logic [13:0][7:0] GVTD_MASK = {
    8'h00, 8'h00,
    8'hf0, 8'hff,
    8'h00, 8'hff,
    8'hff, 8'hff,
    8'hff, 8'hff,
    8'h00, 8'hf8,
    8'hff, 8'hff
  };

  // register bus request
  typedef struct packed {
    logic [11:0] address;
    logic        read;
    logic        write;
    logic [31:0] writedata;
    logic [3:0]  byteenable;
  } gvtd_avs_req_t;

  // command byte stream
  typedef struct packed {
    logic       valid;
    logic       sop;
    logic [7:0] data;
  } gvtd_byte_t;

  // true when a byte breaks the fixed pattern at its index
  function automatic logic gvtd_mismatch(input logic [7:0] b, input logic [3:0] idx);
    gvtd_mismatch = |((b ^ GVTD_EXPECT[idx]) & GVTD_MASK[idx]);
  endfunction

endpackage

// *** gvtd_crc16.sv ***
`timescale 1ns/1ns
// one byte step of the packet checksum, msb first
module gvtd_crc16 (
  // running value
  input  wire logic [15:0] crc_in,
  // byte to fold in
  input  wire logic [7:0]  byte_in,
  // updated value
  output logic      [15:0] crc_out
);
  import gvtd_pkg::*;

  // bitwise shift register over the eight data bits
  always_comb begin
    logic [15:0] c;
    c = crc_in;
    for (int i = 7; i >= 0; i--) begin
      if (c[15] ^ byte_in[i]) begin
        c = {c[14:0], 1'b0} ^ GVTD_CRC_POLY;
      end else begin
        c = {c[14:0], 1'b0};
      end
    end
    crc_out = c;
  end

endmodule // gvtd_crc16

// *** gvtd_decoder.sv ***
`timescale 1ns/1ns
// Functional notes
// - header starts version 000, type 1, header flag 1, process 1000111, category 1100
// - length field must be 7; any other value makes the packet malformed
// - secondary header: service version 000, then checksum flag set to one
// - acknowledgement field must be 0001, acceptance only
// - service type must be 192
// - subtype 1 selects this command; a pad byte follows
// - data word holds 0 to 15, then a 16-bit checksum
// - codes 0..15 step the oscillator from 9.36V down to 8.32V
// - a valid command drives its code out at once
// - accepted code lands in bits 0..3 of the control word at 800
// - command also works in continuum mode, with phase lock bypassed
// - code bits 0..3 appear on control bits 16..19; here they read back on status bits 0..3 and control reads only bit 0
// - reset or software restart sets the code to 4
module gvtd_decoder (
  // clock and reset
  input  wire logic                    clk_in,
  input  wire logic                    rst_n_in,
  // register bus
  input  wire gvtd_pkg::gvtd_avs_req_t avs_req_in,
  output logic                         avs_waitrequest_out,
  output logic [31:0]                  avs_readdata_out,
  // command byte stream
  input  wire gvtd_pkg::gvtd_byte_t    tc_byte_in,
  output logic                         tc_accept_out,
  output logic                         tc_reject_out,
  // sensor unit control outputs
  output logic [3:0]                   gunn_code_out,
  output logic                         pll_bypass_out
);
  import gvtd_pkg::*;

  // whole state of the block
  typedef struct packed {
    logic [3:0]  code;
    logic [3:0]  code_pend;
    logic        cont_mode;
    logic        active;
    logic        bad;
    logic [3:0]  idx;
    logic [15:0] crc;
    logic [13:0] seq_pend;
    logic [13:0] seq_last;
    logic [15:0] acc_cnt;
    logic [15:0] rej_cnt;
    logic        accept;
    logic        reject;
    logic        waitreq;
    logic [31:0] rdata;
  } gvtd_state_t;

  gvtd_state_t state_ff;
  gvtd_state_t nxt_state;
  logic [15:0] crc_seed;
  logic [15:0] crc_step;
  logic [13:0] pos_bad;   // one pattern flag per byte position

  // checksum runs from the seed on a start byte
  assign crc_seed = tc_byte_in.sop ? GVTD_CRC_INIT : state_ff.crc;

  gvtd_crc16 u_crc (
    .crc_in  (crc_seed),
    .byte_in (tc_byte_in.data),
    .crc_out (crc_step)
  );

  // fixed pattern check at every byte position, picked later by the packet index
  for (genvar g = 0; g < GVTD_PKT_BYTES; g++) begin : g_pos
    assign pos_bad[g] = gvtd_mismatch(tc_byte_in.data, 4'(g));
  end

  // lane 0 write aimed at one register
  function automatic logic lane0_write(input gvtd_avs_req_t r, input logic [11:0] a);
    lane0_write = r.write && r.byteenable[0] && (r.address == a);
  endfunction

  // register read mux
  function automatic logic [31:0] read_mux(input logic [11:0] a, input gvtd_state_t s);
    logic [31:0] d;
    d = 32'h0000_0000;
    unique case (a)
      GVTD_ADDR_CTRL: begin
        d[GVTD_CTRL_CONT_BIT] = s.cont_mode;
      end
      GVTD_ADDR_STATUS: begin
        d[3:0] = s.code;
        d[GVTD_STAT_ACTIVE_BIT] = s.active;
        d[GVTD_STAT_SEQ_LSB +: 14] = s.seq_last;
      end
      GVTD_ADDR_COUNT: begin
        d = {s.rej_cnt, s.acc_cnt};
      end
      default: begin
        d = 32'h0000_0000; // unmapped and write-only read zero
      end
    endcase
    read_mux = d;
  endfunction

  // next state
  always_comb begin
    logic       bad_now;
    logic [7:0] b;
    bad_now = 1'b0;
    b = tc_byte_in.data;
    nxt_state = state_ff;
    nxt_state.accept = 1'b0;
    nxt_state.reject = 1'b0;
    nxt_state.waitreq = 1'b1;

    // bus: latch read data, drop waitrequest for one cycle
    if ((avs_req_in.read || avs_req_in.write) && state_ff.waitreq) begin
      nxt_state.waitreq = 1'b0;
      if (avs_req_in.read) begin
        nxt_state.rdata = read_mux(avs_req_in.address, state_ff);
      end
    end

    // bus: write takes effect at the edge waitrequest is seen low
    if (!state_ff.waitreq && avs_req_in.write) begin
      if (lane0_write(avs_req_in, GVTD_ADDR_CTRL)) begin
        nxt_state.cont_mode = avs_req_in.writedata[GVTD_CTRL_CONT_BIT];
        if (avs_req_in.writedata[GVTD_CTRL_RESTART_BIT]) begin
          nxt_state.code = GVTD_CODE_RESET;
        end
      end
      if (lane0_write(avs_req_in, GVTD_ADDR_SUCW)) begin
        nxt_state.code = avs_req_in.writedata[3:0];
      end
    end

    // command stream
    if (tc_byte_in.valid) begin
      if (tc_byte_in.sop) begin
        // a start cuts short any unfinished packet
        if (state_ff.active) begin
          nxt_state.reject = 1'b1;
          nxt_state.rej_cnt = state_ff.rej_cnt + 16'h0001;
        end
        nxt_state.active = 1'b1;
        nxt_state.idx = 4'h1;
        nxt_state.bad = pos_bad[0];
        nxt_state.crc = crc_step;
      end else if (state_ff.active) begin
        bad_now = state_ff.bad | pos_bad[state_ff.idx];
        nxt_state.bad = bad_now;
        nxt_state.crc = crc_step;
        nxt_state.idx = state_ff.idx + 4'h1;
        if (state_ff.idx == GVTD_IDX_SEQ_HI) begin
          nxt_state.seq_pend[13:8] = b[5:0];
        end
        if (state_ff.idx == GVTD_IDX_SEQ_LO) begin
          nxt_state.seq_pend[7:0] = b;
        end
        // code held back until the checksum has been seen
        if (state_ff.idx == GVTD_IDX_DATA) begin
          nxt_state.code_pend = b[3:0];
        end
        if (state_ff.idx == GVTD_IDX_LAST) begin
          nxt_state.active = 1'b0;
          // crc over data and checksum leaves a zero residue
          if (!bad_now && crc_step == 16'h0000) begin
            nxt_state.accept = 1'b1;
            nxt_state.seq_last = state_ff.seq_pend;
            nxt_state.acc_cnt = state_ff.acc_cnt + 16'h0001;
          end else begin
            nxt_state.reject = 1'b1;
            nxt_state.rej_cnt = state_ff.rej_cnt + 16'h0001;
          end
        end
      end
    end

    // accepted code goes out at once, in any mode; beats a register write
    if (nxt_state.accept) begin
      nxt_state.code = state_ff.code_pend;
    end
  end

  // state register
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      state_ff <= '0;
      state_ff.code <= GVTD_CODE_RESET;
      state_ff.crc <= GVTD_CRC_INIT;
      state_ff.waitreq <= 1'b1;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // outputs straight from the state register
  assign avs_waitrequest_out = state_ff.waitreq;
  assign avs_readdata_out    = state_ff.rdata;
  assign tc_accept_out       = state_ff.accept;
  assign tc_reject_out       = state_ff.reject;
  assign gunn_code_out       = state_ff.code;
  assign pll_bypass_out      = state_ff.cont_mode;

endmodule // gvtd_decoder

// *** gvtd_props.sv ***
`timescale 1ns/1ns
// port checks on the decoder
module gvtd_props (
  input wire logic                    clk_in,
  input wire logic                    rst_n_in,
  input wire gvtd_pkg::gvtd_avs_req_t avs_req_in,
  input wire logic                    avs_waitrequest_out,
  input wire gvtd_pkg::gvtd_byte_t    tc_byte_in,
  input wire logic                    tc_accept_out,
  input wire logic                    tc_reject_out,
  input wire logic [3:0]              gunn_code_out,
  input wire logic                    pll_bypass_out
);
  import gvtd_pkg::*;
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  property p_rst; $rose(rst_n_in) |-> gunn_code_out == 4'h4; endproperty
  a_rst: assert property (p_rst) else $error("code after reset");
  property p_hold; $changed(gunn_code_out) |-> tc_accept_out || $past(avs_req_in.write);
  endproperty
  a_hold: assert property (p_hold) else $error("code moved alone");
  property p_rej; tc_reject_out |-> $stable(gunn_code_out); endproperty
  a_rej: assert property (p_rej) else $error("code moved on drop");
  property p_both; !(tc_accept_out && tc_reject_out); endproperty
  a_both: assert property (p_both) else $error("accept and drop");
  property p_acc; tc_accept_out |=> !tc_accept_out; endproperty
  a_acc: assert property (p_acc) else $error("accept too long");
  property p_cause; tc_accept_out || tc_reject_out |-> $past(tc_byte_in.valid); endproperty
  a_cause: assert property (p_cause) else $error("verdict without byte");
  property p_byp; $changed(pll_bypass_out) |-> $past(avs_req_in.write); endproperty
  a_byp: assert property (p_byp) else $error("bypass moved alone");
  property p_ans; (avs_req_in.read || avs_req_in.write) && avs_waitrequest_out
    |=> !avs_waitrequest_out; endproperty
  a_ans: assert property (p_ans) else $error("no bus answer");
  property p_wt; !avs_waitrequest_out |=> avs_waitrequest_out; endproperty
  a_wt: assert property (p_wt) else $error("answer too long");
endmodule // gvtd_props

bind gvtd_decoder gvtd_props chk_i (.clk_in(clk_in), .rst_n_in(rst_n_in),
  .avs_req_in(avs_req_in), .avs_waitrequest_out(avs_waitrequest_out),
  .tc_byte_in(tc_byte_in), .tc_accept_out(tc_accept_out), .tc_reject_out(tc_reject_out),
  .gunn_code_out(gunn_code_out), .pll_bypass_out(pll_bypass_out));

// *** gvtd_src.sv ***
`timescale 1ns/1ns
// ground command source
module gvtd_src (
  // clock
  input  wire logic            clk_in,
  // command bytes
  output gvtd_pkg::gvtd_byte_t byte_out
);
  import gvtd_pkg::*;
  logic [10:0] seq_ff = 11'h000;
  initial byte_out = '0;
  // build, checksum and send a packet; flip spoils byte bad
  task automatic send(input logic [3:0] k, input int bad, input logic [7:0] flip, input int gap);
    logic [0:11][7:0] p;
    logic [15:0]      c;
    logic [7:0]       b;
    p = {16'h1c7c, 5'h18, seq_ff, 56'h000711c0010000, 4'h0, k};
    c = GVTD_CRC_INIT;
    for (int i = 0; i < 12; i++) begin
      c = c ^ {p[i], 8'h00};
      for (int j = 0; j < 8; j++) c = c[15] ? {c[14:0], 1'b0} ^ GVTD_CRC_POLY : {c[14:0], 1'b0};
    end
    seq_ff = seq_ff + 11'h001;
    for (int i = 0; i < 14; i++) begin
      b = i < 12 ? p[i] : (i == 12 ? c[15:8] : c[7:0]);
      if (i == bad) b = b ^ flip;
      byte_out <= '{1'b1, i == 0, b};
      @(posedge clk_in);
      if (gap > 0) begin
        byte_out <= '{1'b0, 1'b0, ~b}; // idle data toggles
        repeat (gap) @(posedge clk_in);
      end
    end
    if (gap == 0) byte_out <= '{1'b0, 1'b0, ~b};
    @(posedge clk_in);
  endtask
endmodule // gvtd_src

// *** tb_top.sv ***
`timescale 1ns/1ns
// decoder bench
module tb_top;
  import gvtd_pkg::*;
  logic          clk_in = 1'b0;
  logic          rst_n_in = 1'b0;
  gvtd_avs_req_t req = '0;
  gvtd_byte_t    tcb;
  logic          wt, acc, rej, byp;
  logic [31:0]   rd;
  logic [3:0]    code, cur;
  logic [4:0]    expq[$];
  int            fails = 0, total_checks = 0, seed = 35, cyc = 0;
  initial forever #5 clk_in = ~clk_in;
  gvtd_decoder uut (.clk_in(clk_in), .rst_n_in(rst_n_in), .avs_req_in(req),
    .avs_waitrequest_out(wt), .avs_readdata_out(rd), .tc_byte_in(tcb), .tc_accept_out(acc),
    .tc_reject_out(rej), .gunn_code_out(code), .pll_bypass_out(byp));
  gvtd_src src (.clk_in(clk_in), .byte_out(tcb));
  // verdict
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    total_checks++;
    if (g !== e) begin
      fails++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  // one bus access, held until waitrequest low
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    req <= '{a, !w, w, d, 4'hf};
    @(posedge clk_in);
    while (wt !== 1'b0) @(posedge clk_in);
    q = rd;
    req <= '0;
    @(posedge clk_in);
  endtask
  task automatic rdc(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    chk(q & m, e);
  endtask
  task automatic pkt(input logic [3:0] k, input int bad, input logic [7:0] f, input int gap);
    if (f == 8'h00) cur = k;
    expq.push_back({f != 8'h00, cur});
    src.send(k, bad, f, gap);
  endtask
  // verdicts against oldest note; cycle ceiling
  always @(posedge clk_in) begin
    cyc <= cyc + 1;
    if (acc === 1'b1 || rej === 1'b1) chk({rej, code}, expq.pop_front());
    if (cyc >= 5000) begin
      fails++;
      wrap_up();
    end
  end
  // main sequence
  initial begin
    logic [31:0] q;
    repeat (3) @(posedge clk_in);
    rst_n_in <= 1'b1;
    rdc(GVTD_ADDR_STATUS, 32'hf, 32'h4);
    for (int i = 0; i < 16; i++) pkt(i[3:0], 0, 8'h00, $random(seed) & 3);
    for (int i = 0; i < 14; i++) pkt(4'h3, i, 8'h01 | 8'($random(seed)), 0);
    rdc(GVTD_ADDR_STATUS, 32'h3fff_010f, 32'h000f_000f);
    rdc(GVTD_ADDR_COUNT, 32'hffffffff, 32'h000e_0010);
    bus(1'b1, GVTD_ADDR_SUCW, 32'h9, q);
    cur = 4'h9;
    rdc(GVTD_ADDR_STATUS, 32'hf, 32'h9);
    bus(1'b1, GVTD_ADDR_CTRL, 32'h2, q);
    cur = 4'h4;
    rdc(GVTD_ADDR_STATUS, 32'hf, 32'h4);
    bus(1'b1, GVTD_ADDR_CTRL, 32'h1, q);
    chk({31'h0, byp}, 32'h1);
    rdc(GVTD_ADDR_CTRL, 32'h3, 32'h1);
    pkt(4'hf, 0, 8'h00, 2);
    rdc(GVTD_ADDR_SUCW, 32'hffffffff, 32'h0);
    rdc(12'h100, 32'hffffffff, 32'h0);
    repeat (4) @(posedge clk_in);
    chk(expq.size(), 32'h0);
    wrap_up();
  end
endmodule // tb_top
